// [bench/acltm_front_end.sv]
`timescale 1ns/1ps
module acltm_front_end
(
    input  wire logic       mclk,
    input  wire logic       active,
    output logic            sample_strobe,
    output logic      [2:0] i_sample,
    output logic      [2:0] q_sample,
    output logic      [6:0] phase_error
);
    logic st;

    initial
    begin
        sample_strobe = 1'b0;
        i_sample      = 3'h3;
        q_sample      = 3'h4;
        phase_error   = 7'h00;
    end

    // Samples are only promised with the strobe; between strobes they flip
    always @(posedge mclk)
    begin
        st = active && ($urandom_range(0, 2) != 0);
        sample_strobe <= st;
        i_sample      <= st ? 3'($urandom_range(0, 7)) : ~i_sample;
        q_sample      <= st ? 3'($urandom_range(0, 7)) : ~q_sample;
        phase_error   <= 7'($urandom);
    end
endmodule // acltm_front_end

// [bench/acltm_monitor.sv]
`timescale 1ns/1ps
module acltm_monitor
#(
    parameter int CAL_PERIOD_CYCLES = 20
)
(
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       sample_strobe,
    input wire logic [2:0] i_sample,
    input wire logic [2:0] q_sample,
    input wire logic [6:0] phase_error,
    input wire logic       tx_symbol_mark,
    input wire logic [4:0] cal_level_value,
    input wire logic [7:0] test_bus_out,
    input wire logic       test_strobe_out
);
    logic [4:0]  sel_reg;
    logic [4:0]  last_reg;
    logic [15:0] gap_reg;
    logic        run_reg;
    logic        seen_reg;
    wire         lvl_chg = cal_level_value != last_reg;

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    // Shadow of the select and mode fields, seen only through bus writes
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            sel_reg  <= 5'h00;
            run_reg  <= 1'b0;
            seen_reg <= 1'b0;
            gap_reg  <= 16'h0000;
            last_reg <= 5'h10;
        end
        else
        begin
            if (reg_wr && reg_addr == 8'h70)
                sel_reg <= reg_wdata[4:0];
            if (reg_wr && reg_addr == 8'h08)
                run_reg <= reg_wdata[4];
            seen_reg <= run_reg && (seen_reg || lvl_chg);
            gap_reg  <= lvl_chg ? 16'h0000 : gap_reg + 16'h0001;
            last_reg <= cal_level_value;
        end
    end

    readback_bus_a: assert property ($past(reg_rd) && $past(reg_addr) == 8'h74 |->
        reg_rdata == $past(test_bus_out)) else $error("readback differs from test bus");
    quiet_mode_a: assert property (sel_reg == 5'h00 && $past(sel_reg) == 5'h00 |->
        test_bus_out == 8'h00 && !test_strobe_out) else $error("quiet mode not quiet");
    iq_mode_a: assert property (sel_reg == 5'h15 && $past(sel_reg) == 5'h15 |->
        test_bus_out == {2'b00, $past(i_sample), $past(q_sample)} && test_strobe_out == $past(sample_strobe))
        else $error("sample mode bus wrong");
    phase_mode_a: assert property (sel_reg == 5'h12 && $past(sel_reg) == 5'h12 |->
        test_bus_out == {$past(phase_error[6]), $past(phase_error)}) else $error("phase mode bus wrong");
    tx_strobe_a: assert property (sel_reg == 5'h02 && $past(sel_reg) == 5'h02 |->
        test_strobe_out == $past(tx_symbol_mark)) else $error("field mode strobe wrong");
    dac_mid_a: assert property (!run_reg && !$past(run_reg) |-> cal_level_value == 5'h10)
        else $error("level not mid scale while off");
    off_acc_a: assert property (!run_reg && !$past(run_reg, 2) && sel_reg == 5'h19 && $past(sel_reg) == 5'h19
        |-> test_bus_out == 8'h00 && !test_strobe_out) else $error("accumulator not preset");
    dac_rate_a: assert property (lvl_chg && run_reg && seen_reg |->
        gap_reg >= CAL_PERIOD_CYCLES - 2) else $error("level refreshed too often");

    cover property (reg_rd && reg_addr == 8'h74);
    cover property (sel_reg == 5'h15 && sample_strobe);
    cover property (lvl_chg && run_reg);
endmodule // acltm_monitor

bind acltm_top acltm_monitor #(.CAL_PERIOD_CYCLES(CAL_PERIOD_CYCLES)) mon_u (.mclk(mclk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sample_strobe(sample_strobe), .i_sample(i_sample), .q_sample(q_sample), .phase_error(phase_error),
    .tx_symbol_mark(tx_symbol_mark), .cal_level_value(cal_level_value), .test_bus_out(test_bus_out),
    .test_strobe_out(test_strobe_out));

// [bench/acltm_test.sv]
`timescale 1ns/1ps
module acltm_test;
    localparam int PER = 20;
    logic        mclk, rst, reg_wr, reg_rd, rpe, trk, fe_on, sst, tstb;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, bus, rv;
    logic [15:0] misc;
    logic [2:0]  smp_i, smp_q;
    logic [6:0]  pe;
    logic [4:0]  lvl;
    logic [8:0]  exp_q, exp_d;
    logic [7:0]  msk;
    logic [5:0]  rssi_m;
    logic [4:0]  cur_sel;
    logic        sat_m, rstb_m, full;
    int          fail_count, tests_run, cycles, acc;
    byte         up_s, dn_s;
    bit          mrun;
    logic [7:0]  ra [6] = '{8'h08, 8'h0c, 8'h10, 8'h70, 8'h74, 8'h40};
    logic [7:0]  rx [6] = '{8'h00, 8'h01, 8'hff, 8'h00, 8'h00, 8'h00};
    logic [4:0]  sels [6] = '{5'h00, 5'h02, 5'h03, 5'h0c, 5'h12, 5'h15};

    acltm_front_end fe_u (.mclk(mclk), .active(fe_on), .sample_strobe(sst), .i_sample(smp_i),
        .q_sample(smp_q), .phase_error(pe));
    acltm_top #(.CAL_PERIOD_CYCLES(PER)) dut_u (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .receive_power_enable(rpe), .track_flag(trk), .sample_strobe(sst), .i_sample(smp_i),
        .q_sample(smp_q), .rssi_value(misc[13:8]), .rssi_strobe(misc[14]), .energy_detect_flag(misc[15]),
        .carrier_sense_flag(misc[3]), .tx_symbol_mark(misc[0]), .transmit_enable_internal(misc[1]),
        .preamble_start(misc[2]), .sfd_start(misc[3]), .signal_start(misc[4]), .length_start(misc[5]),
        .crc_start(misc[6]), .mpdu_start(misc[7]), .phase_error(pe), .cal_level_value(lvl),
        .test_bus_out(bus), .test_strobe_out(tstb));

    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // Reference accumulator, saturating like the hardware, and the expected test port
    always @(posedge mclk)
    begin
        misc <= 16'($urandom);
        cycles++;
        if (cycles == 12000)
        begin
            fail_count++;
            complete_run();
        end
        full = (smp_i == 0 || smp_i == 7 || smp_q == 0 || smp_q == 7);
        exp_d <= exp_q;
        // Strobe in bit 8; the mux shows inputs one cycle late
        case (cur_sel)
            5'h02: exp_q <= {misc[0], sat_m, misc[1], misc[2], misc[3], misc[4], misc[5], misc[6], misc[7]};
            5'h03: exp_q <= {rstb_m, 2'b00, rssi_m};
            5'h0c: exp_q <= {1'b0, sat_m, misc[15], 6'h00};
            5'h12: exp_q <= {sst, pe[6], pe};
            5'h15: exp_q <= {sst, 2'b00, smp_i, smp_q};
            default: exp_q <= 9'h000;
        endcase
        rssi_m = rst ? 6'h00 : (misc[14] ? misc[13:8] : rssi_m);
        rstb_m = !rst && misc[14];
        sat_m  = rst ? 1'b0 : (sst ? full : sat_m);
        if (mrun && sst)
        begin
            acc = acc + (full ? int'(up_s) : int'(dn_s));
            acc = (acc < 0) ? 0 : ((acc > 24'hffffff) ? 24'hffffff : acc);
        end
    end

    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
        tests_run++;
        if (e !== g)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask

    task automatic run(input int n);
        @(posedge mclk);
        fe_on <= 1'b1;
        repeat (n) @(posedge mclk);
        fe_on <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask

    task automatic acc_check();
        wr(8'h70, 8'h19);
        rd(8'h74);
        chk("acc_lo", 24'(acc[7:0]), 24'(rv));
        chk("bus_lo", 24'(acc[7:0]), 24'(bus));
        chk("acc_bit8", 24'(acc[8]), 24'(tstb));
        wr(8'h70, 8'h1a);
        rd(8'h74);
        chk("acc_mid", 24'(acc[16:9]), 24'(rv));
        chk("acc_bit17", 24'(acc[17]), 24'(tstb));
        repeat (PER + 2) @(posedge mclk);
        chk("level", 24'(acc[23:19]), 24'(lvl));
    endtask

    task automatic complete_run();
        if (fail_count == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        {rst, reg_wr, reg_rd, rpe, trk, fe_on, mrun} = 7'h40;
        {reg_addr, reg_wdata, misc} = 32'h0;
        {up_s, dn_s} = 16'h01ff;
        acc = 24'h800000;
        {sat_m, rstb_m, rssi_m, cur_sel} = 13'h0000;
        void'($urandom(32'he517f30d));
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        foreach (ra[k])
        begin
            rd(ra[k]);
            chk("reset_reg", 24'(rx[k]), 24'(rv));
        end
        wr(8'h74, 8'h5a);
        wr(8'h40, 8'h5a);
        rd(8'h74);
        chk("readonly", 24'h0, 24'(rv));
        rd(8'h40);
        chk("unmapped", 24'h0, 24'(rv));
        wr(8'h08, 8'h08);
        run(30);
        acc_check();
        wr(8'h08, 8'h10);
        run(30);
        acc_check();
        trk <= 1'b1;
        mrun = 1'b1;
        for (int k = 0; k < 3; k++)
        begin
            if (k > 0)
            begin
                up_s = byte'($urandom_range(1, 127));
                dn_s = byte'(-$urandom_range(1, 128));
            end
            wr(8'h0c, up_s);
            wr(8'h10, dn_s);
            foreach (sels[s])
            begin
                cur_sel = sels[s];
                wr(8'h70, 8'(sels[s]));
                run(25);
                rd(8'h74);
                // Level bits of the calibration test mode are checked elsewhere; its tick strobe is not checked
                msk = (cur_sel == 5'h0c) ? 8'he0 : 8'hff;
                chk("readback", 24'(exp_d[7:0] & msk), 24'(rv & msk));
                chk("test_bus", 24'(exp_q[7:0] & msk), 24'(bus & msk));
                chk("test_strobe", 24'(exp_q[8] && cur_sel != 5'h0c), 24'(tstb && cur_sel != 5'h0c));
            end
            acc_check();
        end
        trk <= 1'b0;
        rpe <= 1'b1;
        wr(8'h08, 8'h18);
        repeat (4) @(posedge mclk);
        run(60);
        acc_check();
        rpe <= 1'b0;
        repeat (4) @(posedge mclk);
        mrun = 1'b0;
        run(40);
        acc_check();
        wr(8'h08, 8'h00);
        acc = 24'h800000;
        acc_check();
        complete_run();
    end
endmodule // acltm_test

// [hdl/acltm_pkg.sv]
package acltm_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_GENERAL_CONFIG = 8'h08;
    localparam logic [7:0] ADDR_CAL_UP_STEP    = 8'h0c;
    localparam logic [7:0] ADDR_CAL_DOWN_STEP  = 8'h10;
    localparam logic [7:0] ADDR_TEST_SELECT    = 8'h70;
    localparam logic [7:0] ADDR_TEST_READBACK  = 8'h74;

    // Reset values
    localparam logic [7:0] RST_GENERAL_CONFIG  = 8'h00;
    localparam logic [7:0] RST_CAL_UP_STEP     = 8'h01;
    localparam logic [7:0] RST_CAL_DOWN_STEP   = 8'hff;
    localparam logic [4:0] RST_TEST_SELECT     = 5'h00;

    // General configuration fields
    localparam int CAL_MODE_LO_BIT = 3;
    localparam int CAL_MODE_HI_BIT = 4;

    // Calibration accumulator
    localparam int ACC_WIDTH = 24;
    localparam int DAC_WIDTH = 5;
    localparam logic [23:0] ACC_MID_SCALE = 24'h800000;
    localparam logic [23:0] ACC_MAX       = 24'hffffff;
    localparam logic [23:0] ACC_MIN       = 24'h000000;
    localparam logic [4:0]  DAC_MID_SCALE = 5'h10;
    localparam logic [2:0]  SAMPLE_MAX    = 3'h7;
    localparam logic [2:0]  SAMPLE_MIN    = 3'h0;

    // Test select codes with behaviour
    localparam logic [4:0] TM_QUIET      = 5'h00;
    localparam logic [4:0] TM_TX_FIELD   = 5'h02;
    localparam logic [4:0] TM_RSSI       = 5'h03;
    localparam logic [4:0] TM_CAL_TEST   = 5'h0c;
    localparam logic [4:0] TM_PHASE_ERR  = 5'h12;
    localparam logic [4:0] TM_IQ_SAMPLE  = 5'h15;
    localparam logic [4:0] TM_CAL_ACC_LO = 5'h19;
    localparam logic [4:0] TM_CAL_ACC_HI = 5'h1a;

    // Timing
    localparam int CLK_PERIOD_PS      = 5000;
    localparam int CAL_PERIOD_US      = 1000;
    localparam int CAL_PERIOD_CYCLES  = (CAL_PERIOD_US * 1000 * 1000) / CLK_PERIOD_PS;
endpackage

// [hdl/acltm_tick.sv]
`timescale 1ns/1ps
module acltm_tick
#(
    parameter int PERIOD_CYCLES = 200000
)
(
    input  wire logic mclk,
    input  wire logic rst,
    output logic      tick_out
);
    logic [31:0] count_reg;
    logic [31:0] count_next;
    logic        last_w;

    assign last_w     = (count_reg == 32'(PERIOD_CYCLES - 1));
    assign count_next = last_w ? 32'h00000000 : count_reg + 32'h00000001;

    // Free running so the update rate never depends on mode changes
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            count_reg <= 32'h00000000;
            tick_out  <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            tick_out  <= last_w;
        end
    end
endmodule // acltm_tick

// [hdl/acltm_top.sv]
// Summary of operation
// - I or Q at full scale adds the up step to the 24-bit accumulator.
// - Neither at full scale adds the signed down step, decrementing it.
// - Only the top five accumulator bits drive the reference D/A.
// - The D/A value is refreshed at a one kilohertz rate.
// - Mode field upper bit zero disables calibration, reference at mid scale.
// - Mode 10 runs while tracking; mode 11 runs while receive power enabled.
// - The 6-bit signal strength result is latched and shown on test paths.
// - A test strobe qualifies the 8-bit test bus in each mode.
// - The test bus value is readable from the test readback register.
// - 32 test codes; code zero drives strobe and bus low.
// - Mode 2 shows transmit field markers, strobed by transmit symbol mark.
// - Modes 25 and 26 show accumulator slices with bits 8 and 17 as strobe.
// - Mode 21 shows two zeros, I sample, Q sample, sample strobe.
// - Mode 18 shows phase error with duplicated sign, sample strobe.
// - The exported calibration value is five bits and drives the D/A.
// - Tracking indication gates calibration in tracking-only mode.
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module acltm_top
#(
    parameter int CAL_PERIOD_CYCLES = acltm_pkg::CAL_PERIOD_CYCLES
)
(
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       receive_power_enable,
    input  wire logic       track_flag,
    input  wire logic       sample_strobe,
    input  wire logic [2:0] i_sample,
    input  wire logic [2:0] q_sample,
    input  wire logic [5:0] rssi_value,
    input  wire logic       rssi_strobe,
    input  wire logic       energy_detect_flag,
    input  wire logic       carrier_sense_flag,
    input  wire logic       tx_symbol_mark,
    input  wire logic       transmit_enable_internal,
    input  wire logic       preamble_start,
    input  wire logic       sfd_start,
    input  wire logic       signal_start,
    input  wire logic       length_start,
    input  wire logic       crc_start,
    input  wire logic       mpdu_start,
    input  wire logic [6:0] phase_error,
    output logic      [4:0] cal_level_value,
    output logic      [7:0] test_bus_out,
    output logic            test_strobe_out
);

    function automatic logic at_full_scale(input logic [2:0] s);
        at_full_scale = (s == acltm_pkg::SAMPLE_MAX) || (s == acltm_pkg::SAMPLE_MIN);
    endfunction

    // Register file
    logic [7:0]  general_config_reg;
    logic [7:0]  cal_up_step_reg;
    logic [7:0]  cal_down_step_reg;
    logic [4:0]  test_select_reg;
    logic [7:0]  test_readback_reg;
    logic [7:0]  reg_rdata_reg;
    logic [7:0]  reg_rdata_next;

    // Synchroniser for the power enable pin
    logic        pe_meta_reg;
    logic        pe_sync_reg;

    // Calibration loop
    logic [23:0] cal_acc_reg;
    logic [23:0] cal_acc_next;
    logic [4:0]  cal_dac_reg;
    logic [4:0]  cal_dac_next;
    logic        cal_sat_reg;
    logic        cal_tick_reg;
    logic        cal_tick;
    logic [1:0]  cal_mode;
    logic        cal_enabled;
    logic        cal_running;
    logic        cal_step_en;
    logic        any_full_scale;
    logic [23:0] step_ext;
    logic [24:0] acc_sum;
    logic        step_negative;
    logic        acc_overflow;
    logic        acc_underflow;

    // Monitors and test mux
    logic [5:0]  rssi_reg;
    logic        rssi_strobe_reg;
    logic [7:0]  test_bus_reg;
    logic [7:0]  test_bus_next;
    logic        test_strobe_reg;
    logic        test_strobe_next;

    // Bus decode
    logic        sel_config;
    logic        sel_up_step;
    logic        sel_down_step;
    logic        sel_test_select;
    logic        sel_readback;
    logic        wr_config;
    logic        wr_up_step;
    logic        wr_down_step;
    logic        wr_test_select;

    assign sel_config      = (reg_addr == acltm_pkg::ADDR_GENERAL_CONFIG);
    assign sel_up_step     = (reg_addr == acltm_pkg::ADDR_CAL_UP_STEP);
    assign sel_down_step   = (reg_addr == acltm_pkg::ADDR_CAL_DOWN_STEP);
    assign sel_test_select = (reg_addr == acltm_pkg::ADDR_TEST_SELECT);
    assign sel_readback    = (reg_addr == acltm_pkg::ADDR_TEST_READBACK);

    assign wr_config       = reg_wr && sel_config;
    assign wr_up_step      = reg_wr && sel_up_step;
    assign wr_down_step    = reg_wr && sel_down_step;
    assign wr_test_select  = reg_wr && sel_test_select;

    // Unmapped reads return zero; readback is read only
    always_comb
    begin
        if (!reg_rd)
            reg_rdata_next = 8'h00;
        else if (sel_config)
            reg_rdata_next = general_config_reg;
        else if (sel_up_step)
            reg_rdata_next = cal_up_step_reg;
        else if (sel_down_step)
            reg_rdata_next = cal_down_step_reg;
        else if (sel_test_select)
            reg_rdata_next = {3'h0, test_select_reg};
        else if (sel_readback)
            reg_rdata_next = test_readback_reg;
        else
            reg_rdata_next = 8'h00;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            general_config_reg <= acltm_pkg::RST_GENERAL_CONFIG;
            cal_up_step_reg    <= acltm_pkg::RST_CAL_UP_STEP;
            cal_down_step_reg  <= acltm_pkg::RST_CAL_DOWN_STEP;
            test_select_reg    <= acltm_pkg::RST_TEST_SELECT;
            reg_rdata_reg      <= 8'h00;
        end
        else
        begin
            if (wr_config)
                general_config_reg <= reg_wdata;
            if (wr_up_step)
                cal_up_step_reg <= reg_wdata;
            if (wr_down_step)
                cal_down_step_reg <= reg_wdata;
            if (wr_test_select)
                test_select_reg <= reg_wdata[4:0];
            reg_rdata_reg <= reg_rdata_next;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            pe_meta_reg <= 1'b0;
            pe_sync_reg <= 1'b0;
        end
        else
        begin
            pe_meta_reg <= receive_power_enable;
            pe_sync_reg <= pe_meta_reg;
        end
    end

    acltm_tick
    #(
        .PERIOD_CYCLES (CAL_PERIOD_CYCLES)
    )
    u_cal_tick
    (
        .mclk     (mclk),
        .rst      (rst),
        .tick_out (cal_tick)
    );

    // Mode field; lower bit is ignored while the upper bit is clear
    assign cal_mode    = general_config_reg[acltm_pkg::CAL_MODE_HI_BIT:acltm_pkg::CAL_MODE_LO_BIT];
    assign cal_enabled = cal_mode[1];
    // Running mode choice; the host must hold power enable for mode 11
    assign cal_running = cal_enabled && (cal_mode[0] ? pe_sync_reg : track_flag);
    assign cal_step_en = cal_running && sample_strobe;

    assign any_full_scale = at_full_scale(i_sample) || at_full_scale(q_sample);

    // Steps are signed bytes so a down step of ff decrements by one
    assign step_ext = any_full_scale
                    ? {{16{cal_up_step_reg[7]}}, cal_up_step_reg}
                    : {{16{cal_down_step_reg[7]}}, cal_down_step_reg};
    assign step_negative = step_ext[23];
    assign acc_sum       = {1'b0, cal_acc_reg} + {1'b0, step_ext};

    // Clamp at the ends instead of wrapping, which would flip the reference
    assign acc_overflow  = !step_negative && acc_sum[24];
    assign acc_underflow = step_negative && !acc_sum[24];

    always_comb
    begin
        if (!cal_enabled)
            cal_acc_next = acltm_pkg::ACC_MID_SCALE;
        else if (!cal_step_en)
            cal_acc_next = cal_acc_reg;
        else if (acc_overflow)
            cal_acc_next = acltm_pkg::ACC_MAX;
        else if (acc_underflow)
            cal_acc_next = acltm_pkg::ACC_MIN;
        else
            cal_acc_next = acc_sum[23:0];
    end

    // D/A value refreshes only on the slow tick while calibration is enabled, to keep loop gain low
    always_comb
    begin
        if (!cal_enabled)
            cal_dac_next = acltm_pkg::DAC_MID_SCALE;
        else if (cal_tick)
            cal_dac_next = cal_acc_reg[23:19];
        else
            cal_dac_next = cal_dac_reg;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            cal_acc_reg  <= acltm_pkg::ACC_MID_SCALE;
            cal_dac_reg  <= acltm_pkg::DAC_MID_SCALE;
            cal_sat_reg  <= 1'b0;
            cal_tick_reg <= 1'b0;
        end
        else
        begin
            cal_acc_reg  <= cal_acc_next;
            cal_dac_reg  <= cal_dac_next;
            cal_sat_reg  <= sample_strobe ? any_full_scale : cal_sat_reg;
            cal_tick_reg <= cal_tick;
        end
    end

    // Signal strength result held until the next conversion
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            rssi_reg        <= 6'h00;
            rssi_strobe_reg <= 1'b0;
        end
        else
        begin
            if (rssi_strobe)
                rssi_reg <= rssi_value;
            rssi_strobe_reg <= rssi_strobe;
        end
    end

    // Reserved and unimplemented codes behave as quiet
    always_comb
    begin
        case (test_select_reg)
            acltm_pkg::TM_TX_FIELD:
            begin
                test_strobe_next = tx_symbol_mark;
                test_bus_next    = {cal_sat_reg, transmit_enable_internal,
                                    preamble_start, sfd_start, signal_start,
                                    length_start, crc_start, mpdu_start};
            end
            acltm_pkg::TM_RSSI:
            begin
                test_strobe_next = rssi_strobe_reg;
                test_bus_next    = {2'b00, rssi_reg};
            end
            acltm_pkg::TM_CAL_TEST:
            begin
                test_strobe_next = cal_tick_reg;
                test_bus_next    = {cal_sat_reg, energy_detect_flag,
                                    !cal_enabled, cal_dac_reg};
            end
            acltm_pkg::TM_PHASE_ERR:
            begin
                test_strobe_next = sample_strobe;
                test_bus_next    = {phase_error[6], phase_error};
            end
            acltm_pkg::TM_IQ_SAMPLE:
            begin
                test_strobe_next = sample_strobe;
                test_bus_next    = {2'b00, i_sample, q_sample};
            end
            acltm_pkg::TM_CAL_ACC_LO:
            begin
                test_strobe_next = cal_acc_reg[8];
                test_bus_next    = cal_acc_reg[7:0];
            end
            acltm_pkg::TM_CAL_ACC_HI:
            begin
                test_strobe_next = cal_acc_reg[17];
                test_bus_next    = cal_acc_reg[16:9];
            end
            default:
            begin
                test_strobe_next = 1'b0;
                test_bus_next    = 8'h00;
            end
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            test_bus_reg      <= 8'h00;
            test_strobe_reg   <= 1'b0;
            test_readback_reg <= 8'h00;
        end
        else
        begin
            test_bus_reg      <= test_bus_next;
            test_strobe_reg   <= test_strobe_next;
            test_readback_reg <= test_bus_next;
        end
    end

    // Carrier sense is accepted for the acquisition monitor, not yet shown
    logic unused_cs;
    assign unused_cs = carrier_sense_flag;

    assign reg_rdata       = reg_rdata_reg;
    assign cal_level_value = cal_dac_reg;
    assign test_bus_out    = test_bus_reg;
    assign test_strobe_out = test_strobe_reg;

endmodule // acltm_top
